// >>> hdl/trsc_top.v
// Command interpreter for trigger edge, settle-done polarity, status queries, row modes and setup copy.
`timescale 1ns/1ps
`default_nettype none
`include "trsc_defines.vh"

module trsc_top #(
  parameter integer CMD_DEPTH = `TRSC_CMD_DEPTH,
  parameter integer TICK_CYC = `TRSC_TICK_CYC,
  parameter integer HW_SETTLE_US = `TRSC_HW_SETTLE_US
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_reset_n,
  // Decoded command stream and device clear
  input wire i_cmd_valid,
  input wire [7:0] i_cmd_op,
  input wire [15:0] i_cmd_arg0,
  input wire [15:0] i_cmd_arg1,
  output wire o_cmd_ready,
  output reg o_cmd_error,
  input wire i_dev_clear,
  // Trigger sources
  input wire i_ext_trig,
  input wire i_trig_enable,
  input wire i_trig_src_ext,
  input wire i_other_trig,
  // Relay side
  input wire i_relay_op,
  input wire [15:0] i_prog_settle_ms,
  output reg o_load_valid,
  output reg [6:0] o_load_setup,
  output reg o_copy_valid,
  output reg [6:0] o_copy_src,
  output reg [6:0] o_copy_dst,
  // Status sources
  input wire [15:0] i_machine_status,
  input wire [15:0] i_error_status,
  input wire [2:0] i_slave_count,
  input wire [15:0] i_digital_in,
  // Query answers
  output reg o_resp_valid,
  output reg [2:0] o_resp_code,
  output reg [6:0] o_resp_arg,
  output reg [15:0] o_resp_data,
  // Configuration and state
  output wire o_edge_rising,
  output wire o_ready_active_high,
  output wire [7:0] o_make_break_rows,
  output wire [7:0] o_break_make_rows,
  output wire [6:0] o_step_ptr,
  // Settle-done
  output reg o_settle_done_pin,
  output wire o_settle_done_status
);

  localparam integer AW = (CMD_DEPTH > 1) ? $clog2(CMD_DEPTH) : 1;

  // ----------------------------------------------------------------
  // Command buffer
  // ----------------------------------------------------------------
  reg [7:0] buf_op [0:CMD_DEPTH-1];
  reg [15:0] buf_a0 [0:CMD_DEPTH-1];
  reg [15:0] buf_a1 [0:CMD_DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;
  reg exec_q;
  wire is_exec;
  wire full;
  wire take;
  wire store;
  wire pop;
  wire [7:0] op;
  wire [15:0] a0;
  wire [15:0] a1;

  assign is_exec = (i_cmd_op == `TRSC_OP_EXEC);
  assign full = (count_q == CMD_DEPTH[AW:0]);
  // Execute is always taken when idle, so a full buffer can never deadlock the controller.
  assign o_cmd_ready = ~exec_q & (~full | is_exec);
  assign take = i_cmd_valid & o_cmd_ready;
  assign store = take & ~is_exec;
  assign pop = exec_q & (count_q != {(AW+1){1'b0}});
  assign op = buf_op[rd_ptr_q];
  assign a0 = buf_a0[rd_ptr_q];
  assign a1 = buf_a1[rd_ptr_q];

  always @(posedge i_mclk)
  begin
    if (store)
    begin
      buf_op[wr_ptr_q] <= i_cmd_op;
      buf_a0[wr_ptr_q] <= i_cmd_arg0;
      buf_a1[wr_ptr_q] <= i_cmd_arg1;
    end
  end

  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
      exec_q <= 1'b0;
    end
    else if (i_dev_clear)
    begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
      exec_q <= 1'b0;
    end
    else
    begin
      if (store)
      begin
        wr_ptr_q <= (wr_ptr_q == CMD_DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
        count_q <= count_q + 1'b1;
      end
      if (take & is_exec)
      begin
        exec_q <= 1'b1;
      end
      if (pop)
      begin
        rd_ptr_q <= (rd_ptr_q == CMD_DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
        count_q <= count_q - 1'b1;
      end
      else if (exec_q)
      begin
        exec_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Trigger qualification
  // ----------------------------------------------------------------
  reg ext_prev_q;
  reg edge_q;
  wire ext_edge;
  wire trig_fire;

  assign ext_edge = edge_q ? (i_ext_trig & ~ext_prev_q) : (~i_ext_trig & ext_prev_q);
  assign trig_fire = (ext_edge & i_trig_src_ext & i_trig_enable) | i_other_trig;

  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ext_prev_q <= 1'b0;
    end
    else
    begin
      ext_prev_q <= i_ext_trig;
    end
  end

  // ----------------------------------------------------------------
  // Command execution and configuration state
  // ----------------------------------------------------------------
  reg pol_q;
  reg [7:0] mkbk_q;
  reg [7:0] bkmk_q;
  reg [6:0] step_q;
  wire [6:0] step_next;
  wire restore;
  wire bin_ok;
  wire copy_ok;

  assign step_next = (step_q >= `TRSC_SETUP_MAX) ? `TRSC_STEP_FIRST : step_q + 7'h01;
  assign restore = i_dev_clear | (pop & (op == `TRSC_OP_RESTORE) & (a0 == 16'h0000));
  assign bin_ok = (a0 <= `TRSC_ARG_ONE);
  assign copy_ok = (a0 <= `TRSC_SETUP_MAX) & (a1 <= `TRSC_SETUP_MAX);

  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      edge_q <= `TRSC_EDGE_RST;
      pol_q <= `TRSC_POL_RST;
      mkbk_q <= `TRSC_ROWS_RST;
      bkmk_q <= `TRSC_ROWS_RST;
      step_q <= `TRSC_STEP_RST;
      o_load_valid <= 1'b0;
      o_load_setup <= 7'h00;
      o_copy_valid <= 1'b0;
      o_copy_src <= 7'h00;
      o_copy_dst <= 7'h00;
      o_cmd_error <= 1'b0;
    end
    else
    begin
      o_load_valid <= 1'b0;
      o_copy_valid <= 1'b0;
      o_cmd_error <= 1'b0;
      if (trig_fire)
      begin
        step_q <= step_next;
        o_load_valid <= 1'b1;
        o_load_setup <= step_next;
      end
      if (restore)
      begin
        edge_q <= `TRSC_EDGE_RST;
        pol_q <= `TRSC_POL_RST;
        mkbk_q <= `TRSC_ROWS_RST;
        bkmk_q <= `TRSC_ROWS_RST;
      end
      else if (pop)
      begin
        case (op)
          `TRSC_OP_EDGE:
          begin
            if (bin_ok)
              edge_q <= a0[0];
            else
              o_cmd_error <= 1'b1;
          end
          `TRSC_OP_POL:
          begin
            if (bin_ok)
              pol_q <= a0[0];
            else
              o_cmd_error <= 1'b1;
          end
          `TRSC_OP_MKBK:
          begin
            mkbk_q <= a0[7:0];
          end
          `TRSC_OP_BKMK:
          begin
            bkmk_q <= a0[7:0];
          end
          `TRSC_OP_COPY:
          begin
            if (copy_ok)
            begin
              o_copy_valid <= 1'b1;
              o_copy_src <= a0[6:0];
              o_copy_dst <= a1[6:0];
            end
            else
            begin
              o_cmd_error <= 1'b1;
            end
          end
          `TRSC_OP_STATUS:
          begin
            if ((a0 > `TRSC_U_DIGIN) ||
                ((a0 == `TRSC_U_SETUP) && (a1 > `TRSC_SETUP_MAX)) ||
                ((a0 == `TRSC_U_MODELS) && (a1 > `TRSC_UNIT_MAX)))
              o_cmd_error <= 1'b1;
          end
          `TRSC_OP_RESTORE:
          begin
            o_cmd_error <= 1'b1;
          end
          default:
          begin
            o_cmd_error <= 1'b1;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Status query answers
  // ----------------------------------------------------------------
  reg [15:0] resp_d;
  wire query;

  assign query = pop & ~i_dev_clear & (op == `TRSC_OP_STATUS) & ~(
    (a0 > `TRSC_U_DIGIN) ||
    ((a0 == `TRSC_U_SETUP) && (a1 > `TRSC_SETUP_MAX)) ||
    ((a0 == `TRSC_U_MODELS) && (a1 > `TRSC_UNIT_MAX)));

  // Setup dumps and card model lists are formatted outside; only the selector is passed on.
  always @*
  begin
    resp_d = 16'h0000;
    case (a0)
      `TRSC_U_MACHINE: resp_d = i_machine_status;
      `TRSC_U_ERROR: resp_d = i_error_status;
      `TRSC_U_SETUP: resp_d = {9'h000, a1[6:0]};
      `TRSC_U_STEP: resp_d = {9'h000, step_q};
      `TRSC_U_SLAVES: resp_d = {13'h0000, i_slave_count};
      `TRSC_U_MODELS: resp_d = {13'h0000, a1[2:0]};
      `TRSC_U_SETTLE: resp_d = i_prog_settle_ms;
      `TRSC_U_DIGIN: resp_d = i_digital_in;
      default: resp_d = 16'h0000;
    endcase
  end

  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_resp_valid <= 1'b0;
      o_resp_code <= 3'h0;
      o_resp_arg <= 7'h00;
      o_resp_data <= 16'h0000;
    end
    else
    begin
      o_resp_valid <= query;
      if (query)
      begin
        o_resp_code <= a0[2:0];
        o_resp_arg <= a1[6:0];
        o_resp_data <= resp_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Settle-done
  // ----------------------------------------------------------------
  wire settle_ready;
  wire kick;

  // Any relay operation, trigger load or copy into the relays restarts settling.
  assign kick = i_relay_op | trig_fire | (o_copy_valid & (o_copy_dst == 7'h00));

  trsc_settle #(
    .TICK_CYC(TICK_CYC),
    .HW_SETTLE_US(HW_SETTLE_US)
  ) u_settle (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_kick(kick),
    .i_prog_ms(i_prog_settle_ms),
    .o_ready(settle_ready)
  );

  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_settle_done_pin <= 1'b0;
    end
    else
    begin
      o_settle_done_pin <= pol_q ? settle_ready : ~settle_ready;
    end
  end

  assign o_settle_done_status = settle_ready;
  assign o_edge_rising = edge_q;
  assign o_ready_active_high = pol_q;
  assign o_make_break_rows = mkbk_q;
  assign o_break_make_rows = bkmk_q;
  assign o_step_ptr = step_q;

endmodule
`default_nettype wire

// >>> common/trsc_defines.vh
// Constants shared by the trigger, settle-done and status command logic.
`ifndef TRSC_DEFINES_VH
`define TRSC_DEFINES_VH

// ----------------------------------------------------------------
// Command letters, ASCII upper case
// ----------------------------------------------------------------
`define TRSC_OP_EDGE 8'h41
`define TRSC_OP_POL 8'h42
`define TRSC_OP_RESTORE 8'h52
`define TRSC_OP_STATUS 8'h55
`define TRSC_OP_MKBK 8'h56
`define TRSC_OP_BKMK 8'h57
`define TRSC_OP_EXEC 8'h58
`define TRSC_OP_COPY 8'h5A

// ----------------------------------------------------------------
// Field values and reset values
// ----------------------------------------------------------------
`define TRSC_EDGE_FALL 1'b0
`define TRSC_EDGE_RISE 1'b1
`define TRSC_POL_LOW 1'b0
`define TRSC_POL_HIGH 1'b1
`define TRSC_EDGE_RST `TRSC_EDGE_FALL
`define TRSC_POL_RST `TRSC_POL_LOW
`define TRSC_ROWS_RST 8'h00
`define TRSC_STEP_RST 7'h00
`define TRSC_STEP_FIRST 7'h01
`define TRSC_SETUP_MAX 16'h0064
`define TRSC_UNIT_MAX 16'h0004
`define TRSC_ARG_ONE 16'h0001

// ----------------------------------------------------------------
// Status query selectors
// ----------------------------------------------------------------
`define TRSC_U_MACHINE 16'h0000
`define TRSC_U_ERROR 16'h0001
`define TRSC_U_SETUP 16'h0002
`define TRSC_U_STEP 16'h0003
`define TRSC_U_SLAVES 16'h0004
`define TRSC_U_MODELS 16'h0005
`define TRSC_U_SETTLE 16'h0006
`define TRSC_U_DIGIN 16'h0007

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TRSC_CLK_NS 10
`define TRSC_TICK_NS 1000
`define TRSC_TICK_CYC ((`TRSC_TICK_NS + `TRSC_CLK_NS - 1) / `TRSC_CLK_NS)
`define TRSC_US_PER_MS 1000
`define TRSC_HW_SETTLE_US 1000
`define TRSC_CMD_DEPTH 8

`endif

// >>> hdl/trsc_settle.v
// Settle-done timer: hardware settling plus programmed settling after each relay operation.
`timescale 1ns/1ps
`default_nettype none
`include "trsc_defines.vh"

module trsc_settle #(
  parameter integer TICK_CYC = `TRSC_TICK_CYC,
  parameter integer HW_SETTLE_US = `TRSC_HW_SETTLE_US
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_reset_n,
  // Control
  input wire i_kick,
  input wire [15:0] i_prog_ms,
  // Status
  output wire o_ready
);

  reg busy_q;
  reg [15:0] div_q;
  reg [31:0] rem_q;
  wire tick;
  wire [31:0] total;

  assign tick = (div_q == TICK_CYC[15:0] - 16'h0001);
  assign total = HW_SETTLE_US[31:0] + ({16'h0000, i_prog_ms} * `TRSC_US_PER_MS);

  // A kick while busy restarts the full wait, so back-to-back switching extends it.
  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      busy_q <= 1'b0;
      div_q <= 16'h0000;
      rem_q <= 32'h0000_0000;
    end
    else if (i_kick)
    begin
      busy_q <= 1'b1;
      div_q <= 16'h0000;
      rem_q <= total;
    end
    else if (busy_q)
    begin
      if (tick)
      begin
        div_q <= 16'h0000;
        if (rem_q == 32'h0000_0000)
        begin
          busy_q <= 1'b0;
        end
        else
        begin
          rem_q <= rem_q - 32'h0000_0001;
        end
      end
      else
      begin
        div_q <= div_q + 16'h0001;
      end
    end
  end

  assign o_ready = ~busy_q;

endmodule
`default_nettype wire

// >>> verification/trsc_host_model.sv
// Behavioural bus controller and external trigger source facing the command logic.
`timescale 1ns/1ps
`default_nettype none
`include "trsc_defines.vh"
module trsc_host_model (
  // Clock and handshake
  input wire logic i_mclk,
  input wire logic i_cmd_ready,
  // Command word and trigger jack
  output logic o_cmd_valid,
  output logic [7:0] o_cmd_op,
  output logic [15:0] o_cmd_arg0,
  output logic [15:0] o_cmd_arg1,
  output logic o_ext_trig
);
  // ------------------------------------------------------------
  // Idle lines carry the inverse of the last word, so a stale value is never read as fresh.
  // ------------------------------------------------------------
  initial
  begin
    o_cmd_valid = 1'b0;
    o_cmd_op = 8'hff;
    o_cmd_arg0 = 16'hffff;
    o_cmd_arg1 = 16'hffff;
    o_ext_trig = 1'b0;
  end
  // A word that is never taken hangs here on purpose; the bench watchdog then fails the run.
  task automatic send(input logic [7:0] op, input logic [15:0] a0, input logic [15:0] a1);
    @(negedge i_mclk);
    o_cmd_valid = 1'b1;
    o_cmd_op = op;
    o_cmd_arg0 = a0;
    o_cmd_arg1 = a1;
    @(posedge i_mclk);
    while (i_cmd_ready !== 1'b1)
    begin
      @(posedge i_mclk);
    end
    @(negedge i_mclk);
    o_cmd_valid = 1'b0;
    o_cmd_op = ~op;
    o_cmd_arg0 = ~a0;
    o_cmd_arg1 = ~a1;
  endtask
  task automatic cmd_str(input logic [7:0] op, input logic [15:0] a0, input logic [15:0] a1);
    send(op, a0, a1);
    send(`TRSC_OP_EXEC, 16'h0000, 16'h0000);
  endtask
  task automatic trig(input logic lvl);
    @(negedge i_mclk);
    o_ext_trig = lvl;
    repeat (12) @(negedge i_mclk);
  endtask
endmodule
`default_nettype wire

// >>> verification/trsc_top_chk.sv
// Assertion checker for the trigger, settle-done and command ports.
`timescale 1ns/1ps
`default_nettype none
`include "trsc_defines.vh"
module trsc_top_chk #(
  parameter integer TICK_CYC = `TRSC_TICK_CYC,
  parameter integer HW_SETTLE_US = `TRSC_HW_SETTLE_US
) (
  // Clock, reset and commands
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_op,
  input wire logic o_cmd_ready,
  input wire logic i_dev_clear,
  // Triggers and relays
  input wire logic i_trig_enable,
  input wire logic i_trig_src_ext,
  input wire logic i_other_trig,
  input wire logic i_relay_op,
  input wire logic [15:0] i_prog_settle_ms,
  input wire logic o_load_valid,
  input wire logic [6:0] o_load_setup,
  input wire logic [6:0] o_step_ptr,
  // Queries and state
  input wire logic [15:0] i_digital_in,
  input wire logic o_resp_valid,
  input wire logic [2:0] o_resp_code,
  input wire logic [15:0] o_resp_data,
  input wire logic [7:0] o_make_break_rows,
  input wire logic [7:0] o_break_make_rows,
  input wire logic o_ready_active_high,
  input wire logic o_settle_done_pin,
  input wire logic o_settle_done_status
);
  integer low_q;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);
  // Counts how long settle-done has been low; a new kick only lengthens the stretch.
  always @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      low_q <= 0;
    else if (o_settle_done_status)
      low_q <= 0;
    else
      low_q <= low_q + 1;
  end
  sequence s_exec;
    i_cmd_valid && o_cmd_ready && i_cmd_op == `TRSC_OP_EXEC && !i_dev_clear;
  endsequence
  sequence s_busy;
    !o_cmd_ready;
  endsequence
  chk_pin_sense: assert property (o_settle_done_pin == ($past(o_ready_active_high) ~^ $past(o_settle_done_status)))
    else $error("settle pin sense wrong");
  chk_relay_drop: assert property (i_relay_op |-> ##[1:2] !o_settle_done_status)
    else $error("relay op kept settle high");
  chk_load_step: assert property (o_load_valid |-> o_load_setup == o_step_ptr &&
    o_step_ptr == (($past(o_step_ptr) == 7'd100) ? 7'd1 : $past(o_step_ptr) + 7'd1)) else $error("step load wrong");
  chk_trig_gate: assert property (!i_other_trig && !(i_trig_src_ext && i_trig_enable) |=> !o_load_valid)
    else $error("ungated trigger loaded");
  chk_settle_min: assert property ($rose(o_settle_done_status) |->
    low_q >= (HW_SETTLE_US + i_prog_settle_ms * 1000) * TICK_CYC) else $error("settle too short");
  chk_settle_max: assert property ($fell(o_settle_done_status) && i_prog_settle_ms == 16'h0000
    |-> ##[1:40] o_settle_done_status) else $error("settle too long");
  chk_exec_busy: assert property (s_exec |=> s_busy)
    else $error("execute did not start");
  chk_rows_quiet: assert property ($changed(o_make_break_rows) || $changed(o_break_make_rows)
    |-> $past(o_cmd_ready) == 1'b0 || $past(i_dev_clear)) else $error("rows changed outside execution");
  chk_step_query: assert property (o_resp_valid && o_resp_code == 3'd3 |-> o_resp_data == {9'h000, o_step_ptr})
    else $error("step query data wrong");
  chk_digin_query: assert property (o_resp_valid && o_resp_code == 3'd7 |-> o_resp_data == $past(i_digital_in))
    else $error("digital input query wrong");
endmodule
bind trsc_top trsc_top_chk #(.TICK_CYC(TICK_CYC), .HW_SETTLE_US(HW_SETTLE_US)) u_chk (.*);
`default_nettype wire

// >>> verification/trsc_top_tb_top.sv
// Testbench top for the trigger, settle-done and status command logic.
`timescale 1ns/1ps
`default_nettype none
`include "trsc_defines.vh"
module trsc_top_tb_top;
  logic i_mclk, i_reset_n, i_cmd_valid, o_cmd_ready, o_cmd_error, i_dev_clear, i_ext_trig, i_trig_enable;
  logic i_trig_src_ext, i_other_trig, i_relay_op, o_load_valid, o_copy_valid, o_resp_valid, st_q;
  logic o_edge_rising, o_ready_active_high, o_settle_done_pin, o_settle_done_status;
  logic [7:0] i_cmd_op, o_make_break_rows, o_break_make_rows;
  logic [15:0] i_cmd_arg0, i_cmd_arg1, i_prog_settle_ms, i_machine_status, i_error_status, i_digital_in, o_resp_data;
  logic [6:0] o_load_setup, o_copy_src, o_copy_dst, o_resp_arg, o_step_ptr;
  logic [2:0] i_slave_count, o_resp_code;
  logic [25:0] r_resp;
  logic [13:0] r_copy;
  int err_total = 0, n_tests = 0, n_load = 0, n_err = 0, n_fall = 0;
  // Short settling parameters keep the hardware settle wait to a few cycles.
  trsc_top #(.TICK_CYC(2), .HW_SETTLE_US(2)) dut (.*);
  trsc_host_model host (.i_mclk(i_mclk), .i_cmd_ready(o_cmd_ready), .o_cmd_valid(i_cmd_valid),
    .o_cmd_op(i_cmd_op), .o_cmd_arg0(i_cmd_arg0), .o_cmd_arg1(i_cmd_arg1), .o_ext_trig(i_ext_trig));
  initial
  begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk)
  begin
    st_q <= o_settle_done_status;
    if (o_load_valid === 1'b1) n_load <= n_load + 1;
    if (o_cmd_error === 1'b1) n_err <= n_err + 1;
    if (st_q === 1'b1 && o_settle_done_status === 1'b0) n_fall <= n_fall + 1;
    if (o_resp_valid === 1'b1) r_resp <= {o_resp_code, o_resp_arg, o_resp_data};
    if (o_copy_valid === 1'b1) r_copy <= {o_copy_src, o_copy_dst};
  end
  task automatic cmp(input logic [25:0] got, input logic [25:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (err_total == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic run(input logic [7:0] op, input logic [15:0] a0, input logic [15:0] a1);
    int n;
    host.cmd_str(op, a0, a1);
    n = 0;
    @(negedge i_mclk);
    while (o_cmd_ready !== 1'b1 && n < 40)
    begin
      n++;
      @(negedge i_mclk);
    end
    cmp(n < 40, 1'b1);
    repeat (12) @(negedge i_mclk);
  endtask
  task automatic t_edge;
    int i;
    i_trig_src_ext = 1'b1;
    i_trig_enable = 1'b1;
    run(`TRSC_OP_EDGE, 16'h0001, 16'h0000);
    host.trig(1'b1);
    host.trig(1'b0);
    cmp({o_edge_rising, o_step_ptr}, {1'b1, 7'd1});
    run(`TRSC_OP_EDGE, 16'h0000, 16'h0000);
    host.trig(1'b1);
    host.trig(1'b0);
    cmp({o_edge_rising, o_step_ptr}, {1'b0, 7'd2});
    i_trig_enable = 1'b0;
    host.trig(1'b1);
    host.trig(1'b0);
    i_trig_enable = 1'b1;
    i_trig_src_ext = 1'b0;
    host.trig(1'b1);
    host.trig(1'b0);
    cmp(o_step_ptr, 7'd2);
    // Enough triggers to pass the top setup and come round to step 3.
    for (i = 0; i < 101; i++)
    begin
      i_other_trig = 1'b1;
      @(negedge i_mclk);
      i_other_trig = 1'b0;
      repeat (12) @(negedge i_mclk);
    end
    cmp({o_step_ptr, n_load[6:0]}, {7'd3, 7'd103});
  endtask
  task automatic t_settle(input logic [15:0] ms, input logic pol);
    int n;
    int lo;
    run(`TRSC_OP_POL, {15'h0000, pol}, 16'h0000);
    i_prog_settle_ms = ms;
    cmp({o_ready_active_high, o_settle_done_status, o_settle_done_pin}, {pol, 1'b1, pol});
    i_relay_op = 1'b1;
    @(negedge i_mclk);
    i_relay_op = 1'b0;
    lo = (2 + ms * 1000) * 2;
    n = 0;
    repeat (3) @(negedge i_mclk);
    cmp({o_settle_done_status, o_settle_done_pin}, {1'b0, ~pol});
    while (o_settle_done_status !== 1'b1 && n < 3000)
    begin
      n++;
      @(negedge i_mclk);
    end
    @(negedge i_mclk);
    cmp({n + 4 >= lo && n + 4 <= lo + 12, o_settle_done_pin}, {1'b1, pol});
  endtask
  task automatic t_query;
    logic [15:0] exp [8];
    int s;
    i_prog_settle_ms = 16'h00c8;
    i_machine_status = 16'h1234;
    i_error_status = 16'h8001;
    i_slave_count = 3'd4;
    i_digital_in = 16'hffff;
    exp = '{16'h1234, 16'h8001, 16'h0000, 16'h0003, 16'h0004, 16'h0000, 16'h00c8, 16'hffff};
    for (s = 0; s < 8; s++)
    begin
      run(`TRSC_OP_STATUS, s[15:0], (s == 2) ? 16'h0064 : 16'h0004);
      cmp(r_resp[25:16], {s[2:0], (s == 2) ? 7'd100 : 7'd4});
      if (s != 2 && s != 5) cmp(r_resp[15:0], exp[s]);
    end
    i_prog_settle_ms = 16'h0000;
    i_slave_count = 3'd1;
    i_digital_in = 16'h5a3c;
    run(`TRSC_OP_STATUS, 16'h0004, 16'h0000);
    cmp(r_resp[15:0], 16'h0001);
    run(`TRSC_OP_STATUS, 16'h0007, 16'h0000);
    cmp(r_resp[15:0], 16'h5a3c);
    run(`TRSC_OP_STATUS, 16'h0002, 16'h0065);
    run(`TRSC_OP_STATUS, 16'h0005, 16'h0005);
    cmp(n_err[6:0], 7'd2);
  endtask
  task automatic t_rows;
    host.send(`TRSC_OP_MKBK, 16'h00a5, 16'h0000);
    repeat (4) @(negedge i_mclk);
    cmp(o_make_break_rows, 8'h00);
    run(`TRSC_OP_BKMK, 16'h005a, 16'h0000);
    cmp({o_make_break_rows, o_break_make_rows}, 16'ha55a);
    run(`TRSC_OP_MKBK, 16'h00ff, 16'h0000);
    run(`TRSC_OP_BKMK, 16'h0000, 16'h0000);
    cmp({o_make_break_rows, o_break_make_rows}, 16'hff00);
  endtask
  // Settle falls are counted from the start of this task, since every earlier fired trigger and relay operation drops it too.
  task automatic t_copy;
    int f0;
    f0 = n_fall;
    run(`TRSC_OP_COPY, 16'h0005, 16'h0000);
    cmp({r_copy, 7'(n_fall - f0)}, {7'd5, 7'd0, 7'd1});
    run(`TRSC_OP_COPY, 16'h0000, 16'h0064);
    run(`TRSC_OP_COPY, 16'h0065, 16'h0000);
    cmp({r_copy, 7'(n_fall - f0), n_err[6:0]}, {7'd0, 7'd100, 7'd1, 7'd3});
  endtask
  task automatic t_restore;
    run(`TRSC_OP_EDGE, 16'h0001, 16'h0000);
    run(`TRSC_OP_POL, 16'h0001, 16'h0000);
    run(`TRSC_OP_RESTORE, 16'h0000, 16'h0000);
    cmp({o_edge_rising, o_ready_active_high, o_make_break_rows}, 10'h000);
    run(`TRSC_OP_RESTORE, 16'h0001, 16'h0000);
    run(`TRSC_OP_EDGE, 16'h0001, 16'h0000);
    run(`TRSC_OP_POL, 16'h0001, 16'h0000);
    i_dev_clear = 1'b1;
    @(negedge i_mclk);
    i_dev_clear = 1'b0;
    repeat (4) @(negedge i_mclk);
    cmp({o_edge_rising, o_ready_active_high, o_settle_done_pin, n_err[6:0]}, {3'b000, 7'd4});
  endtask
  initial
  begin
    i_reset_n = 1'b0;
    i_dev_clear = 1'b0;
    i_trig_enable = 1'b0;
    i_trig_src_ext = 1'b0;
    i_other_trig = 1'b0;
    i_relay_op = 1'b0;
    i_prog_settle_ms = 16'h0000;
    i_machine_status = 16'h0000;
    i_error_status = 16'h0000;
    i_slave_count = 3'd0;
    i_digital_in = 16'h0000;
    repeat (4) @(negedge i_mclk);
    i_reset_n = 1'b1;
    @(negedge i_mclk);
    cmp({o_edge_rising, o_ready_active_high, o_settle_done_status, o_settle_done_pin, o_step_ptr}, 11'h100);
    t_edge;
    t_settle(16'h0001, 1'b1);
    t_settle(16'h0000, 1'b0);
    t_query;
    t_rows;
    t_copy;
    t_restore;
    finish_test;
  end
  // The whole sequence needs under 6000 cycles; this margin only trips on a hang.
  initial
  begin
    repeat (40000) @(posedge i_mclk);
    err_total++;
    finish_test;
  end
endmodule
`default_nettype wire
